// file: rtl/dual_edge_gpio_pkg.sv
/*
  constants shared by the dual-edge gpio i/o logic and its fifo.
  assumes nothing of its surroundings.
*/
package dual_edge_gpio_pkg;
  // ==========================================================
  // data layout
  localparam int DATA_W = 2;
  localparam int RISE_EDGE_BIT = 0;
  localparam int FALL_EDGE_BIT = 1;
  // ==========================================================
  // transmit buffer
  localparam int TX_FIFO_DEPTH = 32;
  // ==========================================================
  // reset values
  localparam logic PAD_BIT_RST = 1'h0;
  localparam logic OE_RST = 1'h0;
  localparam logic [DATA_W-1:0] WORD_RST = 2'h0;
endpackage : dual_edge_gpio_pkg

// file: rtl/gpio_tx_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module gpio_tx_fifo
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  wire is_empty = (wr_ptr_q == rd_ptr_q);
  wire is_full = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) &&
    (wr_ptr_q[AW] != rd_ptr_q[AW]);

  assign o_in_ready = !is_full;
  assign o_out_valid = !is_empty;
  assign o_out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  a_fifo_full_refuse: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) is_full |-> !o_in_ready)
    else $error("fifo accepts while full");
endmodule : gpio_tx_fifo

// file: rtl/dual_edge_gpio_io.sv
/*
  gpio i/o logic between one pad and the fabric: receive, transmit
  and drive-enable registers, unregistered bypass, dual-edge mode.
  assumes the mode inputs are static while the clocks run and the
  fabric keeps the drive enable meaningful.
*/
`timescale 1ns/1ps
module dual_edge_gpio_io
  import dual_edge_gpio_pkg::*;
(
  // transmit clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // receive clock
  input wire logic i_rx_reg_clock,
  // configuration
  input wire logic i_dual_edge_mode,
  input wire logic i_resync_mode,
  input wire logic i_rx_reg_en,
  input wire logic i_oe_reg_en,
  input wire logic i_diff_pair_pad,
  // fabric transmit stream
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_tx_ready,
  input wire logic i_tx_run,
  input wire logic i_drive_en,
  // fabric receive and bypass
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_bypass_path,
  // pad
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe
);
  // ==========================================================
  // mode decode
  // differential-pair pads never run dual edge
  wire dual_on = i_dual_edge_mode && !i_diff_pair_pad;
  wire resync_on = dual_on && i_resync_mode;

  // ==========================================================
  // transmit buffer
  logic head_valid;
  logic [DATA_W-1:0] head_word;
  wire pop = head_valid && i_tx_run;

  gpio_tx_fifo #(.WIDTH(DATA_W), .DEPTH(TX_FIFO_DEPTH)) u_fifo
  (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_tx_ready),
    .o_out_valid(head_valid),
    .o_out_data(head_word),
    .i_out_ready(i_tx_run)
  );

  // ==========================================================
  // transmit registers, transmit clock only
  logic tx_rise_q;
  logic tx_fall_hold_q;
  logic tx_fall_q;
  logic oe_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      tx_rise_q <= PAD_BIT_RST;
      tx_fall_hold_q <= PAD_BIT_RST;
      oe_q <= OE_RST;
    end
    else
    begin
      if (pop)
      begin
        tx_rise_q <= head_word[RISE_EDGE_BIT];
        tx_fall_hold_q <= head_word[FALL_EDGE_BIT];
      end
      oe_q <= i_drive_en;
    end
  end

  // bit 1 comes from the hold flop loaded at the rise of the same pop:
  // the fifo head has already moved on by the fall, so reading it
  // there would launch the next word's bit 1
  wire tx_fall_d = tx_fall_hold_q;

  always_ff @(negedge i_sys_clk)
  begin
    if (!i_reset_n)
      tx_fall_q <= PAD_BIT_RST;
    else
      tx_fall_q <= tx_fall_d;
  end

  // with dual edge on, high phase shows the rise bit, low phase the fall bit; otherwise the rise bit in both phases
  wire pad_bit = dual_on ? (i_sys_clk ? tx_rise_q : tx_fall_q)
    : tx_rise_q;
  wire drive_eff = i_oe_reg_en ? oe_q : i_drive_en;

  assign o_pad_out = drive_eff ? pad_bit : PAD_BIT_RST;
  assign o_pad_oe = drive_eff;

  // ==========================================================
  // receive reset crossing
  // reset is synchronous to the transmit clock, so it is resampled
  logic rx_rst_meta_q;
  logic rx_rst_n_q;

  always_ff @(posedge i_rx_reg_clock)
  begin
    rx_rst_meta_q <= i_reset_n;
    rx_rst_n_q <= rx_rst_meta_q;
  end

  // ==========================================================
  // receive registers, receive clock only
  logic rx_rise_q;
  logic rx_fall_q;
  logic rx_fall_sync_q;

  always_ff @(posedge i_rx_reg_clock)
  begin
    if (!rx_rst_n_q)
    begin
      rx_rise_q <= PAD_BIT_RST;
      rx_fall_sync_q <= PAD_BIT_RST;
    end
    else
    begin
      rx_rise_q <= i_pad_in;
      rx_fall_sync_q <= rx_fall_q;
    end
  end

  always_ff @(negedge i_rx_reg_clock)
  begin
    if (!rx_rst_n_q)
      rx_fall_q <= PAD_BIT_RST;
    else
      rx_fall_q <= i_pad_in;
  end

  wire rx_bit1 = !dual_on ? PAD_BIT_RST :
    (resync_on ? rx_fall_sync_q : rx_fall_q);
  assign o_rx_data = {rx_bit1, rx_rise_q};

  // bypass carries the raw pad only when no input register is used
  assign o_bypass_path = i_rx_reg_en ? PAD_BIT_RST : i_pad_in;

  // ==========================================================
  // checks, transmit domain
  a_tx_single_edge: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (!dual_on && o_pad_oe) |-> o_pad_out == tx_rise_q)
    else $error("single edge pad not from bit 0");

  a_tx_rise_launch: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    pop |=> tx_rise_q == $past(head_word[RISE_EDGE_BIT]))
    else $error("rise bit not launched");

  a_tx_hold_idle: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !pop |=> $stable(tx_rise_q))
    else $error("transmit register moved without a word");

  a_oe_direct_path: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !i_oe_reg_en |-> o_pad_oe == i_drive_en)
    else $error("direct enable not passed");

  a_oe_reg_path: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (i_oe_reg_en && $past(i_reset_n)) |-> o_pad_oe == $past(i_drive_en))
    else $error("registered enable wrong");

  a_pad_undriven: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !o_pad_oe |-> o_pad_out == PAD_BIT_RST)
    else $error("pad driven while disabled");

  a_diff_pair_single: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (i_diff_pair_pad && o_pad_oe) |-> o_pad_out == tx_rise_q)
    else $error("dual edge on a differential-pair pad");

  a_bypass_route: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !i_rx_reg_en |-> o_bypass_path == i_pad_in)
    else $error("bypass not following pad");

  // ==========================================================
  // checks, receive domain
  a_rx_single_edge: assert property (@(posedge i_rx_reg_clock)
    disable iff (!rx_rst_n_q)
    (!dual_on && $past(rx_rst_n_q)) |->
    o_rx_data == {PAD_BIT_RST, $past(i_pad_in)})
    else $error("single edge receive wrong");

  a_rx_resync_hold: assert property (@(posedge i_rx_reg_clock)
    disable iff (!rx_rst_n_q)
    (resync_on && $past(rx_rst_n_q)) |->
    o_rx_data[FALL_EDGE_BIT] == $past(rx_fall_q))
    else $error("resync fall sample not held");

  c_dual_normal_tx: cover property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) dual_on && !resync_on && pop);
  c_dual_resync_tx: cover property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) resync_on && pop ##1 pop);
  c_fifo_backpressure: cover property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) i_tx_valid && !o_tx_ready);
endmodule : dual_edge_gpio_io

// file: test/gpio_pad_model.sv
/*
  pad source for the receive side: word bit0 is seen at rise,
  bit1 at fall. assumes the word changes just after a rise.
*/
`timescale 1ns/1ps
module gpio_pad_model
(
  // receive clock
  input wire logic i_clk,
  // word to place on the pad
  input wire logic [1:0] i_word,
  // pad level
  output logic o_pad
);
  initial o_pad = 1'h0;
  // set half a period ahead so both edges sample settled data
  always @(negedge i_clk) o_pad <= i_word[0];
  always @(posedge i_clk) o_pad <= i_word[1];
endmodule : gpio_pad_model

// file: test/dual_edge_gpio_io_tb.sv
/*
  self-checking bench: tx fifo to pad, drive enable, rx, bypass.
  assumes the fifo sits inside the design's top module.
*/
`timescale 1ns/1ps
module dual_edge_gpio_io_tb
  import dual_edge_gpio_pkg::*;
;
  // ==========================================================
  // signals
  logic clk = 1'h0, rxc = 1'h0, rst_n = 1'h0, pad;
  logic dual = 1'h0, resync = 1'h0, diff = 1'h0, rx_en = 1'h1;
  logic oe_reg = 1'h0, valid = 1'h0, run = 1'h0, de = 1'h0;
  logic [DATA_W-1:0] txd = 2'h0, rxd, w = 2'h0;
  logic rdy, byp, pout, poe;
  logic [DATA_W-1:0] expq[$];
  logic [2:0] modes [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
  int num_errors = 0, total_checks = 0, seed = 62840, cyc = 0;
  always #2.5 clk = ~clk;
  always #3.5 rxc = ~rxc;
  dual_edge_gpio_io dut (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_rx_reg_clock(rxc), .i_dual_edge_mode(dual),
    .i_resync_mode(resync), .i_rx_reg_en(rx_en), .i_oe_reg_en(oe_reg),
    .i_diff_pair_pad(diff), .i_tx_valid(valid), .i_tx_data(txd),
    .o_tx_ready(rdy), .i_tx_run(run), .i_drive_en(de), .o_rx_data(rxd),
    .o_bypass_path(byp), .i_pad_in(pad), .o_pad_out(pout),
    .o_pad_oe(poe));
  gpio_pad_model pm (.i_clk(rxc), .i_word(w), .o_pad(pad));
  // ==========================================================
  // helpers
  function logic dual_on();
    return dual & ~diff;
  endfunction : dual_on
  task chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // transmit: fill past full while stalled, then drain
  task tx_part();
    logic [1:0] e;
    logic prev;
    de <= 1'h1;
    repeat (33)
    begin
      e = 2'($random(seed));
      txd <= e;
      valid <= 1'h1;
      if (expq.size() < TX_FIFO_DEPTH) expq.push_back(e);
      @(posedge clk);
    end
    #1;
    chk("tx_ready_full", 2'h0, {1'h0, rdy});
    valid <= 1'h0;
    run <= 1'h1;
    while (expq.size() > 0)
    begin
      e = expq.pop_front();
      @(posedge clk);
      #1;
      chk("pad_rise", {1'h0, e[0]}, {1'h0, pout});
      @(negedge clk);
      #1;
      chk("pad_fall", {1'h0, e[dual_on()]}, {1'h0, pout});
    end
    run <= 1'h0;
    repeat (20)
    begin
      @(posedge clk);
      prev = de;
      de <= 1'($random(seed));
      #1;
      chk("pad_oe", {1'h0, oe_reg ? prev : de}, {1'h0, poe});
      if (poe === 1'h0) chk("pad_idle", 2'h0, {1'h0, pout});
    end
  endtask : tx_part
  // ==========================================================
  // receive: q1 is last cycle's word, q2 the one before
  task rx_part();
    logic [1:0] q1, q2;
    q1 = 2'h0;
    for (int n = 0; n < 30; n++)
    begin
      @(posedge rxc);
      q2 = q1;
      q1 = w;
      w <= 2'($random(seed));
      #1;
      if (n < 3) continue;
      chk("rx_rise", {dual_on() & q2[1], q1[0]}, rxd);
      chk("bypass_off", 2'h0, {1'h0, byp});
      @(negedge rxc);
      #1;
      chk("rx_fall", {dual_on() & (resync ? q2[1] : q1[1]), q1[0]},
        rxd);
    end
  endtask : rx_part
  // ==========================================================
  // main sequence over the configurations
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      {dual, resync, diff} = modes[m];
      oe_reg = m[0];
      rst_n <= 1'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      fork
        tx_part();
        rx_part();
      join
    end
    rx_en <= 1'h0;
    repeat (20)
    begin
      @(posedge rxc);
      #1;
      chk("bypass", {1'h0, pad}, {1'h0, byp});
    end
    give_verdict();
  end
endmodule : dual_edge_gpio_io_tb
